// ===== hdl/mmbs_pkg.sv
package mmbs_pkg;
  localparam int OFS_W = 28;
  localparam logic [31:0] DDR_LAST = 32'h0fff_ffff;
  localparam logic [31:0] ASYNC_BASE = 32'hb000_0000;
  localparam logic [31:0] ASYNC_LAST = 32'hbfff_ffff;
  localparam int ASYNC_MAX_BANKS = 4;
  localparam logic [31:0] L2ROM_BASE = 32'hc800_0000;
  localparam logic [31:0] L2ROM_LAST = 32'hc800_7fff;
  localparam logic [31:0] L2SRAM_BASE = 32'hc808_0000;
  localparam int L2_SRAM_MAX_KB = 256;
  localparam int L2_BANKS = 8;
  localparam int L2_PATH_BITS = 64;
  localparam logic [31:0] MMR_SYS_BASE = 32'hffc0_0000;
  localparam logic [31:0] MMR_CORE_BASE = 32'hffe0_0000;
  localparam logic [9:0] L1_C0_TAG = 10'h3fe;
  localparam logic [9:0] L1_C1_TAG = 10'h3fd;
  localparam int L1_DATA_BYTES = 32768;
  localparam int L1_DATA_CACHE_OFS = 16384;
  localparam int L1_INSTR_BYTES = 81920;
  localparam int L1_INSTR_CACHE_OFS = 65536;
  localparam int L1_SCRATCH_BYTES = 4096;
  localparam logic [2:0] L1_SUB_INSTR = 3'h0;
  localparam logic [2:0] L1_SUB_DATA_A = 3'h1;
  localparam logic [2:0] L1_SUB_DATA_B = 3'h2;
  localparam logic [2:0] L1_SUB_SCRATCH = 3'h3;
  localparam logic [3:0] ICACHE_WAYS = 4'h4;
  localparam logic [3:0] DCACHE_WAYS = 4'h2;
  localparam logic [3:0] DCACHE_COUNT = 4'h2;
  localparam logic [3:0] L1_DATA_PORTS = 4'h2;
  localparam logic [3:0] L1_FETCH_PORTS = 4'h1;
  localparam logic [1:0] MST_CORE0 = 2'h0;
  localparam logic [1:0] MST_CORE1 = 2'h1;
  localparam logic [1:0] MST_DMA = 2'h2;
  localparam logic [1:0] OWN_SHARED = 2'h0;
  localparam logic [7:0] REG_L2_OWNER = 8'h00;
  localparam logic [7:0] REG_L1_CACHE = 8'h04;
  localparam logic [7:0] REG_BOOT = 8'h08;
  localparam logic [7:0] REG_SOFT_RST = 8'h0c;
  localparam logic [7:0] REG_ERR = 8'h10;
  localparam logic [7:0] REG_ERR_ADDR = 8'h14;
  localparam logic [7:0] REG_CAPS = 8'h18;
  localparam logic [15:0] L2_OWNER_RST = 16'h0000;
  localparam logic [5:0] L1_CACHE_RST = 6'h00;
  localparam logic [2:0] BOOT_NONE = 3'h0;
  localparam logic [2:0] BOOT_MEMORY = 3'h1;
  localparam logic [2:0] BOOT_CARD_MASTER = 3'h2;
  localparam logic [2:0] BOOT_SERIAL_MASTER = 3'h3;
  localparam logic [2:0] BOOT_SERIAL_SLAVE = 3'h4;
  localparam logic [2:0] BOOT_RSVD = 3'h5;
  localparam logic [2:0] BOOT_LINK_SLAVE = 3'h6;
  localparam logic [1:0] BOOT_SETTLE = 2'h3;
  typedef enum logic [3:0] {
    RG_RESERVED, RG_DDR, RG_ASYNC, RG_L2ROM, RG_L2SRAM,
    RG_L1_C0, RG_L1_C1, RG_MMR_SYS, RG_MMR_CORE
  } mmbs_region_t;
  typedef struct packed {
    mmbs_region_t region;
    logic [2:0] bank;
    logic [OFS_W-1:0] offset;
    logic cache_part;
  } mmbs_dec_t;
endpackage

// ===== hdl/mmbs_dec_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mmbs_dec_if import mmbs_pkg::*;;
  logic [31:0] addr;
  logic [1:0] master;
  logic supervisor;
  logic [15:0] l2_owner;
  logic [5:0] l1_cache;
  mmbs_dec_t dec;
  logic err;
  modport ctl(output addr, master, supervisor, l2_owner, l1_cache, input dec, err);
  modport dcd(input addr, master, supervisor, l2_owner, l1_cache, output dec, err);
endinterface
`default_nettype wire

// ===== hdl/mmbs_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module mmbs_decoder import mmbs_pkg::*; #(
  parameter int L2_SRAM_KB = 256,
  parameter int ASYNC_BANKS = 4
) (
  mmbs_dec_if.dcd dif
);
  localparam logic [31:0] L2SRAM_LAST = 32'(L2SRAM_BASE + L2_SRAM_KB * 1024 - 1);
  localparam int L2_BANK_SH = $clog2(L2_SRAM_KB * 1024 / L2_BANKS);

  function automatic mmbs_dec_t decode_addr(input logic [31:0] a);
    mmbs_dec_t d;
    logic [21:0] r;
    logic [31:0] o;
    d = '0;
    r = a[21:0];
    o = a - L2SRAM_BASE;
    if (a <= DDR_LAST) begin
      d.region = RG_DDR;
      d.offset = a[27:0];
    end else if (a >= ASYNC_BASE && a <= ASYNC_LAST) begin
      d.bank = {1'b0, a[27:26]};
      d.offset = {2'h0, a[25:0]};
      if (32'(a[27:26]) < ASYNC_BANKS) d.region = RG_ASYNC;
    end else if (a >= L2ROM_BASE && a <= L2ROM_LAST) begin
      d.region = RG_L2ROM;
      d.offset = OFS_W'(a - L2ROM_BASE);
    end else if (a >= L2SRAM_BASE && a <= L2SRAM_LAST) begin
      d.region = RG_L2SRAM;
      d.offset = o[27:0];
      d.bank = 3'(o >> L2_BANK_SH);
    end else if (a >= MMR_CORE_BASE) begin
      d.region = RG_MMR_CORE;
    end else if (a >= MMR_SYS_BASE) begin
      d.region = RG_MMR_SYS;
    end else if (a[31:22] == L1_C0_TAG || a[31:22] == L1_C1_TAG) begin
      d.offset = {6'h0, r};
      case (r[21:20])
        2'h0: begin
          d.bank = L1_SUB_DATA_A;
          d.cache_part = 32'(r[19:0]) >= L1_DATA_CACHE_OFS;
          if (32'(r[19:0]) < L1_DATA_BYTES) d.region = RG_L1_C0;
        end
        2'h1: begin
          d.bank = L1_SUB_DATA_B;
          d.cache_part = 32'(r[19:0]) >= L1_DATA_CACHE_OFS;
          if (32'(r[19:0]) < L1_DATA_BYTES) d.region = RG_L1_C0;
        end
        2'h2: begin
          d.bank = L1_SUB_INSTR;
          d.cache_part = 32'(r[19:0]) >= L1_INSTR_CACHE_OFS;
          if (32'(r[19:0]) < L1_INSTR_BYTES) d.region = RG_L1_C0;
        end
        default: begin
          d.bank = L1_SUB_SCRATCH;
          if (32'(r[19:0]) < L1_SCRATCH_BYTES) d.region = RG_L1_C0;
        end
      endcase
      if (d.region == RG_L1_C0 && a[31:22] == L1_C1_TAG) d.region = RG_L1_C1;
    end
    return d;
  endfunction

  mmbs_dec_t d;
  logic [1:0] owner;
  logic cache_on;
  logic mmr;

  always_comb begin
    d = decode_addr(dif.addr);
    owner = dif.l2_owner[2*d.bank +: 2];
    cache_on = dif.l1_cache[(d.region == RG_L1_C1 ? 3 : 0) + int'(d.bank[1:0])];
    mmr = d.region == RG_MMR_SYS || d.region == RG_MMR_CORE;
    if (mmr && dif.master == MST_DMA) d.region = RG_RESERVED;
    dif.dec = d;
    dif.err = d.region == RG_RESERVED || dif.master > MST_DMA
      || (mmr && !dif.supervisor)
      || (d.region == RG_L2SRAM && owner != OWN_SHARED
          && owner != 2'(dif.master + 2'h1))
      || ((d.region == RG_L1_C0 || d.region == RG_L1_C1)
          && d.cache_part && cache_on);
  end
endmodule
`default_nettype wire

// ===== hdl/mmbs_bootsel.sv
`timescale 1ns/1ns
`default_nettype none
module mmbs_bootsel import mmbs_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic recapture,
  input wire logic [2:0] pins,
  output logic [2:0] mode,
  output logic valid,
  output logic fetch,
  output logic receive
);
  logic [2:0] s1_r, s2_r, s3_r;
  logic [1:0] settle_r;
  logic pending_r;

  function automatic logic is_fetch(input logic [2:0] m);
    return m == BOOT_MEMORY || m == BOOT_CARD_MASTER || m == BOOT_SERIAL_MASTER;
  endfunction

  function automatic logic is_receive(input logic [2:0] m);
    return m == BOOT_SERIAL_SLAVE || m == BOOT_LINK_SLAVE;
  endfunction

  always_ff @(posedge clk) begin
    s1_r <= pins;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  always_ff @(posedge clk) begin
    if (rst) settle_r <= 2'h0;
    else if (settle_r != BOOT_SETTLE) settle_r <= settle_r + 2'h1;
  end

  // Armed by power-on reset and by each software reset
  always_ff @(posedge clk) begin
    if (rst) pending_r <= 1'b1;
    else if (recapture) pending_r <= 1'b1;
    else if (settle_r == BOOT_SETTLE && s2_r == s3_r) pending_r <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= BOOT_NONE;
      valid <= 1'b0;
      fetch <= 1'b0;
      receive <= 1'b0;
    end else if (recapture) begin
      valid <= 1'b0;
    end else if (pending_r && settle_r == BOOT_SETTLE && s2_r == s3_r) begin
      mode <= s3_r;
      valid <= 1'b1;
      fetch <= is_fetch(s3_r);
      receive <= is_receive(s3_r);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_arm_stable;
    pending_r && settle_r == BOOT_SETTLE && s2_r == s3_r && !recapture;
  endsequence
  AST_BOOT_CAPTURE: assert property (s_arm_stable |=> valid && mode == $past(s3_r))
    else $error("boot mode not captured from settled pins");
  AST_BOOT_HOLD: assert property (valid && !recapture |=> $stable(mode) && valid)
    else $error("boot mode changed without reset");
  AST_BOOT_CLASS: assert property (valid |-> fetch == is_fetch(mode)
      && receive == is_receive(mode) && !(fetch && receive))
    else $error("boot master/slave class wrong");
endmodule
`default_nettype wire

// ===== hdl/mmbs_top.sv
`timescale 1ns/1ns
`default_nettype none
module mmbs_top import mmbs_pkg::*; #(
  parameter int L2_SRAM_KB = L2_SRAM_MAX_KB,
  parameter int ASYNC_BANKS = ASYNC_MAX_BANKS
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [2:0] BOOT_SELECT_PINS,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REQ_VALID,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [1:0] REQ_MASTER,
  input wire logic REQ_SUPERVISOR,
  input wire logic REQ_WRITE,
  output logic RSP_VALID,
  output logic RSP_ERROR,
  output logic [3:0] RSP_REGION,
  output logic [2:0] RSP_BANK,
  output logic [OFS_W-1:0] RSP_OFFSET,
  output logic [2:0] RSP_LANE,
  output logic RSP_WRITE,
  output logic [2:0] BOOT_MODE,
  output logic BOOT_VALID,
  output logic BOOT_FETCH,
  output logic BOOT_RECEIVE,
  output logic SOFT_RESET,
  output logic [5:0] L1_CACHE_EN,
  output logic L1_PARITY_EN
);
  localparam int LANE_W = $clog2(L2_PATH_BITS / 8);

  mmbs_dec_if dif();
  logic [15:0] l2_owner_r;
  logic [5:0] l1_cache_r;
  logic soft_rst_r;
  logic err_flag_r;
  logic [31:0] err_addr_r;
  logic [31:0] prdata_r;
  logic parity_r;
  logic apb_setup, apb_acc, apb_wr, err_evt;
  mmbs_dec_t dq;

  function automatic logic reg_hit(input logic [31:0] a);
    return a[31:8] == 24'h0 && (a[7:0] == REG_L2_OWNER || a[7:0] == REG_L1_CACHE
      || a[7:0] == REG_BOOT || a[7:0] == REG_SOFT_RST || a[7:0] == REG_ERR
      || a[7:0] == REG_ERR_ADDR || a[7:0] == REG_CAPS);
  endfunction

  assign dif.addr = REQ_ADDR;
  assign dif.master = REQ_MASTER;
  assign dif.supervisor = REQ_SUPERVISOR;
  assign dif.l2_owner = l2_owner_r;
  assign dif.l1_cache = l1_cache_r;
  assign dq = dif.dec;

  mmbs_decoder #(
    .L2_SRAM_KB(L2_SRAM_KB),
    .ASYNC_BANKS(ASYNC_BANKS)
  ) u_dec (
    .dif(dif.dcd)
  );

  mmbs_bootsel u_boot (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .recapture(soft_rst_r),
    .pins(BOOT_SELECT_PINS),
    .mode(BOOT_MODE),
    .valid(BOOT_VALID),
    .fetch(BOOT_FETCH),
    .receive(BOOT_RECEIVE)
  );

  // APB slave, zero wait states
  assign apb_setup = PSEL && !PENABLE;
  assign apb_acc = PSEL && PENABLE;
  assign apb_wr = apb_acc && PWRITE && reg_hit(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = apb_acc && !reg_hit(PADDR);
  assign PRDATA = prdata_r;
  assign err_evt = REQ_VALID && dif.err;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) l2_owner_r <= L2_OWNER_RST;
    else if (apb_wr && PADDR[7:0] == REG_L2_OWNER) l2_owner_r <= PWDATA[15:0];
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) l1_cache_r <= L1_CACHE_RST;
    else if (apb_wr && PADDR[7:0] == REG_L1_CACHE) l1_cache_r <= PWDATA[5:0];
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) soft_rst_r <= 1'b0;
    else soft_rst_r <= apb_wr && PADDR[7:0] == REG_SOFT_RST && PWDATA[0];
  end

  // Parity stays enabled whatever the cache setting
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) parity_r <= 1'b1;
    else parity_r <= 1'b1;
  end

  // Sticky error: a new error in the clearing cycle wins
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) err_flag_r <= 1'b0;
    else if (err_evt) err_flag_r <= 1'b1;
    else if (apb_wr && PADDR[7:0] == REG_ERR && PWDATA[0]) err_flag_r <= 1'b0;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) err_addr_r <= 32'h0;
    else if (err_evt) err_addr_r <= REQ_ADDR;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      prdata_r <= 32'h0;
    end else if (apb_setup) begin
      case (PADDR)
        32'(REG_L2_OWNER): prdata_r <= {16'h0, l2_owner_r};
        32'(REG_L1_CACHE): prdata_r <= {26'h0, l1_cache_r};
        32'(REG_BOOT): prdata_r <= {26'h0, BOOT_VALID, BOOT_RECEIVE, BOOT_FETCH, BOOT_MODE};
        32'(REG_ERR): prdata_r <= {31'h0, err_flag_r};
        32'(REG_ERR_ADDR): prdata_r <= err_addr_r;
        32'(REG_CAPS): prdata_r <= {8'h0, L1_FETCH_PORTS, L1_DATA_PORTS,
          DCACHE_COUNT, DCACHE_WAYS, ICACHE_WAYS, 4'(ASYNC_BANKS)};
        default: prdata_r <= 32'h0;
      endcase
    end
  end

  // Decode answer one cycle after the request
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) RSP_VALID <= 1'b0;
    else RSP_VALID <= REQ_VALID;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      RSP_ERROR <= 1'b0;
      RSP_REGION <= 4'h0;
      RSP_BANK <= 3'h0;
      RSP_OFFSET <= '0;
      RSP_LANE <= 3'h0;
      RSP_WRITE <= 1'b0;
    end else if (REQ_VALID) begin
      RSP_ERROR <= dif.err;
      RSP_REGION <= dq.region;
      RSP_BANK <= dq.bank;
      RSP_WRITE <= REQ_WRITE && !dif.err;
      if (dq.region == RG_L2SRAM || dq.region == RG_L2ROM) begin
        RSP_OFFSET <= {dq.offset[OFS_W-1:LANE_W], LANE_W'(0)};
        RSP_LANE <= 3'(dq.offset[LANE_W-1:0]);
      end else begin
        RSP_OFFSET <= dq.offset;
        RSP_LANE <= 3'h0;
      end
    end else begin
      RSP_WRITE <= 1'b0;
    end
  end

  assign SOFT_RESET = soft_rst_r;
  assign L1_CACHE_EN = l1_cache_r;
  assign L1_PARITY_EN = parity_r;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  logic in_mmr, in_async, in_hole, in_rom, in_l2, l2_locked;
  assign in_mmr = REQ_ADDR >= MMR_SYS_BASE;
  assign in_async = REQ_ADDR >= ASYNC_BASE && REQ_ADDR <= ASYNC_LAST;
  assign in_hole = REQ_ADDR > DDR_LAST && REQ_ADDR < ASYNC_BASE;
  assign in_rom = REQ_ADDR >= L2ROM_BASE && REQ_ADDR <= L2ROM_LAST;
  assign in_l2 = dif.dec.region == RG_L2SRAM;
  assign l2_locked = l2_owner_r[2*dif.dec.bank +: 2] != OWN_SHARED
    && l2_owner_r[2*dif.dec.bank +: 2] != 2'(REQ_MASTER + 2'h1);

  sequence s_bad_req;
    REQ_VALID && (in_hole || (in_mmr && !REQ_SUPERVISOR));
  endsequence
  AST_RESERVED_ERR: assert property (s_bad_req |=> RSP_VALID && RSP_ERROR && !RSP_WRITE)
    else $error("reserved access not refused");
  AST_DDR_MAP: assert property (REQ_VALID && REQ_ADDR <= DDR_LAST
      |=> RSP_REGION == RG_DDR && RSP_OFFSET == $past(REQ_ADDR[27:0]))
    else $error("DDR decode wrong");
  AST_MMR_USER: assert property (REQ_VALID && in_mmr && !REQ_SUPERVISOR |=> RSP_ERROR)
    else $error("user access to registers allowed");
  AST_MMR_DMA: assert property (REQ_VALID && in_mmr && REQ_MASTER == MST_DMA
      |=> RSP_ERROR && RSP_REGION == RG_RESERVED)
    else $error("DMA reached register space");
  AST_ASYNC_BANK: assert property (REQ_VALID && in_async
      |=> RSP_BANK == {1'b0, $past(REQ_ADDR[27:26])})
    else $error("async bank select wrong");
  AST_L2_ROM: assert property (REQ_VALID && in_rom && REQ_MASTER != 2'h3
      |=> RSP_REGION == RG_L2ROM && !RSP_ERROR)
    else $error("boot ROM decode wrong");
  AST_L2_PRIVATE: assert property (REQ_VALID && in_l2 && l2_locked
      |=> RSP_ERROR && !RSP_WRITE)
    else $error("private L2 bank not refused");
  AST_PARITY: assert property (L1_PARITY_EN)
    else $error("L1 parity disabled");
  AST_APB_UNMAPPED: assert property (apb_acc && !reg_hit(PADDR) |-> PSLVERR && PREADY)
    else $error("unmapped APB access not flagged");
endmodule
`default_nettype wire

// ===== testbench/mmbs_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module mmbs_master_model (
  input wire logic clk,
  output logic req_valid,
  output logic [31:0] req_addr,
  output logic [1:0] req_master,
  output logic req_supervisor,
  output logic req_write,
  input wire logic rsp_valid
);
  initial begin
    req_valid = 1'b0;
    req_addr = 32'h0;
    req_master = 2'h0;
    req_supervisor = 1'b0;
    req_write = 1'b0;
  end

  // One request per call; the answer is awaited under a bounded count
  task automatic issue(input logic [31:0] a, input logic [1:0] m, input logic s,
                       input logic w, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_master <= m;
    req_supervisor <= s;
    req_write <= w;
    @(posedge clk);
    req_valid <= 1'b0;
    // Released address, supervisor and write qualifiers toggle so stale values never pass for a request; req_master holds
    req_addr <= ~a;
    req_supervisor <= ~s;
    req_write <= ~w;
    #1;
    while (rsp_valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = (rsp_valid === 1'b1);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_memory_map_boot_select.sv
`timescale 1ns/1ns
`default_nettype none
module tb_memory_map_boot_select import mmbs_pkg::*;;
  localparam int ASYNC_N = 3;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] pins = BOOT_SERIAL_MASTER;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, req_valid, req_supervisor, req_write;
  logic [31:0] req_addr;
  logic [1:0] req_master;
  logic rsp_valid, rsp_error, rsp_write, soft_reset, parity_en;
  logic [3:0] rsp_region;
  logic [2:0] rsp_bank, rsp_lane, boot_mode;
  logic [OFS_W-1:0] rsp_offset;
  logic boot_valid, boot_fetch, boot_receive;
  logic [5:0] cache_en;
  int miscompares = 0;
  int samples_checked = 0;

  always #5 sys_clk = ~sys_clk;

  mmbs_top #(.L2_SRAM_KB(256), .ASYNC_BANKS(ASYNC_N)) DUT (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .BOOT_SELECT_PINS(pins),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .REQ_VALID(req_valid), .REQ_ADDR(req_addr), .REQ_MASTER(req_master),
    .REQ_SUPERVISOR(req_supervisor), .REQ_WRITE(req_write),
    .RSP_VALID(rsp_valid), .RSP_ERROR(rsp_error), .RSP_REGION(rsp_region),
    .RSP_BANK(rsp_bank), .RSP_OFFSET(rsp_offset), .RSP_LANE(rsp_lane),
    .RSP_WRITE(rsp_write), .BOOT_MODE(boot_mode), .BOOT_VALID(boot_valid),
    .BOOT_FETCH(boot_fetch), .BOOT_RECEIVE(boot_receive),
    .SOFT_RESET(soft_reset), .L1_CACHE_EN(cache_en), .L1_PARITY_EN(parity_en)
  );

  mmbs_master_model u_mst (
    .clk(sys_clk), .req_valid(req_valid), .req_addr(req_addr),
    .req_master(req_master), .req_supervisor(req_supervisor),
    .req_write(req_write), .rsp_valid(rsp_valid)
  );

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    chk("pready", 1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic eer);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
    chk("pslverr", eer, er);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic eer);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk("prdata", e, rd);
    chk("pslverr", eer, er);
  endtask

  // Region 4'hf means the region shown with an error is not judged
  task automatic dec(input logic [31:0] a, input logic [1:0] m, input logic s,
                     input logic [3:0] rg, input logic [2:0] bk, input logic er);
    logic ok;
    u_mst.issue(a, m, s, 1'b1, ok);
    chk("rsp_valid", 1, ok);
    chk("rsp_error", er, rsp_error);
    chk("rsp_write", !er, rsp_write);
    if (rg !== 4'hf) chk("rsp_region", rg, rsp_region);
    if (!er && rg inside {RG_ASYNC, RG_L2SRAM, RG_L1_C0, RG_L1_C1})
      chk("rsp_bank", bk, rsp_bank);
  endtask

  task automatic wait_boot(input logic v);
    int n;
    n = 0;
    while (boot_valid !== v && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk("boot_valid", v, boot_valid);
  endtask

  task automatic t_boot_reset;
    wait_boot(1'b1);
    chk("boot_mode", BOOT_SERIAL_MASTER, boot_mode);
    chk("boot_fetch", 1, boot_fetch);
    chk("boot_receive", 0, boot_receive);
    chk("parity_en", 1, parity_en);
    chk("cache_en", 0, cache_en);
  endtask

  task automatic t_boot_modes;
    logic fet, rcv;
    for (int c = 0; c < 8; c++) begin
      pins <= c[2:0];
      repeat (5) @(posedge sys_clk);
      wr({24'h0, REG_SOFT_RST}, 32'h1, 1'b0);
      @(posedge sys_clk);
      chk("soft_reset", 1, soft_reset);
      wait_boot(1'b0);
      chk("soft_reset", 0, soft_reset);
      wait_boot(1'b1);
      pins <= ~c[2:0];
      repeat (6) @(posedge sys_clk);
      fet = (c >= 1 && c <= 3);
      rcv = (c == 4 || c == 6);
      chk("boot_mode", c[2:0], boot_mode);
      rd_chk({24'h0, REG_BOOT}, {26'h0, 1'b1, rcv, fet, c[2:0]}, 1'b0);
      chk("boot_fetch", fet, boot_fetch);
      chk("boot_receive", rcv, boot_receive);
    end
  endtask

  task automatic t_decode_map;
    dec(32'h0000_1000, MST_CORE0, 1'b1, RG_DDR, 0, 1'b0);
    dec(32'h0fff_fffc, MST_DMA, 1'b0, RG_DDR, 0, 1'b0);
    dec(32'h1000_0000, MST_CORE0, 1'b1, RG_RESERVED, 0, 1'b1);
    dec(32'hb000_0000, MST_CORE0, 1'b1, RG_ASYNC, 0, 1'b0);
    dec(32'hb7ff_fffc, MST_CORE1, 1'b1, RG_ASYNC, 1, 1'b0);
    dec(32'hb800_0000, MST_DMA, 1'b1, RG_ASYNC, 2, 1'b0);
    dec(32'hbc00_0000, MST_CORE0, 1'b1, 4'hf, 0, 1'b1);
    dec(32'hc000_0000, MST_CORE0, 1'b1, RG_RESERVED, 0, 1'b1);
    dec(32'hc800_7ffc, MST_CORE0, 1'b1, RG_L2ROM, 0, 1'b0);
    dec(32'hc800_8000, MST_CORE0, 1'b1, RG_RESERVED, 0, 1'b1);
    dec(32'hc808_0000, MST_CORE1, 1'b1, RG_L2SRAM, 0, 1'b0);
    dec(32'hc80b_8000, MST_DMA, 1'b1, RG_L2SRAM, 7, 1'b0);
    dec(32'hc80c_0000, MST_CORE0, 1'b1, RG_RESERVED, 0, 1'b1);
    dec(32'hc808_0005, MST_CORE0, 1'b1, RG_L2SRAM, 0, 1'b0);
    chk("rsp_offset", 0, rsp_offset);
    chk("rsp_lane", 5, rsp_lane);
    dec(32'hffa0_0000, MST_CORE0, 1'b1, RG_L1_C0, 0, 1'b0);
    dec(32'hff80_0000, MST_CORE0, 1'b1, RG_L1_C0, 1, 1'b0);
    dec(32'hff90_0000, MST_CORE0, 1'b1, RG_L1_C0, 2, 1'b0);
    dec(32'hffb0_0ffc, MST_CORE0, 1'b1, RG_L1_C0, 3, 1'b0);
    dec(32'hffb0_1000, MST_CORE0, 1'b1, RG_RESERVED, 0, 1'b1);
    dec(32'hff80_8000, MST_CORE0, 1'b1, RG_RESERVED, 0, 1'b1);
    dec(32'hff60_0000, MST_CORE1, 1'b1, RG_L1_C1, 0, 1'b0);
    dec(32'hff40_0000, MST_CORE1, 1'b1, RG_L1_C1, 1, 1'b0);
    dec(32'hff50_0000, MST_CORE1, 1'b1, RG_L1_C1, 2, 1'b0);
    dec(32'hff70_0000, MST_CORE1, 1'b1, RG_L1_C1, 3, 1'b0);
    dec(32'h0000_1000, 2'h3, 1'b1, 4'hf, 0, 1'b1);
    dec(32'hffc0_0000, MST_CORE0, 1'b1, RG_MMR_SYS, 0, 1'b0);
    dec(32'hffe0_0010, MST_CORE1, 1'b1, RG_MMR_CORE, 0, 1'b0);
    dec(32'hffc0_0000, MST_CORE0, 1'b0, 4'hf, 0, 1'b1);
    dec(32'hffe0_0000, MST_DMA, 1'b1, RG_RESERVED, 0, 1'b1);
  endtask

  task automatic t_l2_owner;
    wr({24'h0, REG_L2_OWNER}, 32'h0000_c001, 1'b0);
    rd_chk({24'h0, REG_L2_OWNER}, 32'h0000_c001, 1'b0);
    dec(32'hc808_0000, MST_CORE1, 1'b1, 4'hf, 0, 1'b1);
    dec(32'hc808_0000, MST_CORE0, 1'b1, RG_L2SRAM, 0, 1'b0);
    dec(32'hc80b_8000, MST_CORE0, 1'b1, 4'hf, 0, 1'b1);
    dec(32'hc80b_8000, MST_DMA, 1'b1, RG_L2SRAM, 7, 1'b0);
    dec(32'hc808_8000, MST_CORE1, 1'b1, RG_L2SRAM, 1, 1'b0);
    wr({24'h0, REG_L2_OWNER}, 32'h0, 1'b0);
  endtask

  task automatic t_l1_cache;
    wr({24'h0, REG_L1_CACHE}, 32'h0000_002a, 1'b0);
    rd_chk({24'h0, REG_L1_CACHE}, 32'h0000_002a, 1'b0);
    chk("cache_en", 6'h2a, cache_en);
    dec(32'hff80_4000, MST_CORE0, 1'b1, 4'hf, 0, 1'b1);
    dec(32'hff80_3ffc, MST_CORE0, 1'b1, RG_L1_C0, 1, 1'b0);
    dec(32'hff90_4000, MST_CORE0, 1'b1, RG_L1_C0, 2, 1'b0);
    dec(32'hff61_0000, MST_CORE1, 1'b1, 4'hf, 0, 1'b1);
    dec(32'hff50_4000, MST_CORE1, 1'b1, 4'hf, 0, 1'b1);
    chk("parity_en", 1, parity_en);
    wr({24'h0, REG_L1_CACHE}, 32'h0, 1'b0);
    dec(32'hff80_4000, MST_CORE0, 1'b1, RG_L1_C0, 1, 1'b0);
  endtask

  task automatic t_err_regs;
    wr({24'h0, REG_ERR}, 32'h1, 1'b0);
    rd_chk({24'h0, REG_ERR}, 32'h0, 1'b0);
    dec(32'h1000_0040, MST_CORE1, 1'b1, RG_RESERVED, 0, 1'b1);
    rd_chk({24'h0, REG_ERR}, 32'h1, 1'b0);
    rd_chk({24'h0, REG_ERR_ADDR}, 32'h1000_0040, 1'b0);
    rd_chk({24'h0, REG_CAPS}, 32'h0012_2243, 1'b0);
    rd_chk(32'h0000_001c, 32'h0, 1'b1);
    wr(32'h0000_0100, 32'hffff_ffff, 1'b1);
    rd_chk({24'h0, REG_L2_OWNER}, 32'h0, 1'b0);
  endtask

  initial begin
    #300000;
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_boot_reset();
    t_decode_map();
    t_l2_owner();
    t_l1_cache();
    t_err_regs();
    t_boot_modes();
    finish_test();
  end
endmodule
`default_nettype wire
